// ### logic/rpo_rx_out_port.sv
// receive parallel output port: output register, char clock pair, apb config
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// Contract
// - Data and status outputs change only right after an edge of the selected clock: a rising edge at full rate, either edge at half rate.
// - With the decoder on, the data outputs carry the decoded byte or special character.
// - With the decoder bypassed, the data outputs carry raw character bits nine down to two.
// - With the decoder bypassed, status bits one and zero carry raw character bits one and zero.
// - With the decoder bypassed, status bit two is high when the held character is a comma.
// - With the decoder on, all three status bits carry the character's encoded status.
// - With parity enabled, the parity output is valid for and timed with the data outputs.
// - With parity control low, the parity output driver is switched off.
// - With recovered clocking selected, outputs are timed to the true/complement clock pair.
// - The recovered clock runs continuously at character rate or half of it per rate select.
// - At full rate the host latches on the true rising edge; at half rate on both edges.
// - With reference clocking, the clock pair follows the reference and rate select is ignored.
// - A half-rate reference clock moves the outputs on both of its edges.
module rpo_rx_out_port import rpo_pkg::*; (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// characters from the framer/decoder
	input  wire logic        char_valid,
	output      logic        char_ready,
	input  wire logic [9:0]  char_raw,
	input  wire logic [7:0]  char_dec_data,
	input  wire logic [2:0]  char_dec_status,
	input  wire logic        char_comma,
	// host-facing outputs
	output      logic [7:0]  rx_data_out,
	output      logic [2:0]  rx_status_out,
	output      logic        rx_odd_parity_out,
	output      logic        rx_odd_parity_oe,
	output      logic        rx_char_clock_pair_true,
	output      logic        rx_char_clock_pair_comp
);

	// =========================================================
	// state
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] div;
		logic [31:0] rdata;
		logic [7:0]  cnt;
		logic        phase;
		logic        phase_n;
		logic [7:0]  data;
		logic [2:0]  status;
		logic        parity;
		logic [7:0]  underruns;
		logic [7:0]  gap;
		logic        cfg_ok;
	} rpo_state_t;

	rpo_state_t st_q;
	rpo_state_t st_d;

	rpo_stream_if #(.W(RPO_CHAR_W)) fifo_push ();
	rpo_stream_if #(.W(RPO_CHAR_W)) fifo_pop ();
	logic [3:0] fifo_level;

	rpo_fifo #(
		.W     (RPO_CHAR_W),
		.DEPTH (RPO_FIFO_DEPTH)
	) u_rpo_fifo (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (fifo_push),
		.pop     (fifo_pop),
		.level   (fifo_level)
	);

	// back-pressure reaches the decoder through char_ready
	assign fifo_push.valid = char_valid;
	assign fifo_push.data  = {char_raw, char_dec_data, char_dec_status, char_comma};
	assign char_ready      = fifo_push.ready;

	// =========================================================
	// configuration decode
	logic [1:0] dec_mode;
	logic [1:0] par_ctl;
	logic [1:0] clk_sel;
	logic       rx_rate;
	logic       ref_rate;
	logic [7:0] rec_period;
	logic [7:0] ref_half;
	logic       use_ref;
	logic       half_rate;
	logic [7:0] half_raw;
	logic [7:0] half_len;

	assign dec_mode   = st_q.ctrl[RPO_CTRL_DEC_LSB +: 2];
	assign par_ctl    = st_q.ctrl[RPO_CTRL_PAR_LSB +: 2];
	assign clk_sel    = st_q.ctrl[RPO_CTRL_SEL_LSB +: 2];
	assign rx_rate    = st_q.ctrl[RPO_CTRL_RXR_BIT];
	assign ref_rate   = st_q.ctrl[RPO_CTRL_REFR_BIT];
	assign rec_period = st_q.div[RPO_DIV_REC_LSB +: 8];
	assign ref_half   = st_q.div[RPO_DIV_REF_LSB +: 8];

	// high clock select is outside this block; it is served like mid
	assign use_ref   = (clk_sel == RPO_TRI_LOW);
	assign half_rate = use_ref ? ref_rate : rx_rate;
	always_comb begin
		if (use_ref) begin
			half_raw = ref_half;
		end else if (rx_rate) begin
			half_raw = rec_period;
		end else begin
			half_raw = {1'b0, rec_period[7:1]};
		end
	end
	// a zero divider would stop the clock, so it is held at one
	assign half_len = (half_raw == 8'h00) ? 8'h01 : half_raw;

	// =========================================================
	// clock divider and character events
	logic       tick;
	logic       char_evt;
	logic       ld;
	logic [21:0] ld_word;
	logic [7:0] nxt_data;
	logic [2:0] nxt_status;

	assign tick     = (st_q.cnt == 8'h00);
	// full rate: rising true edge only; half rate: every edge
	assign char_evt = tick & (half_rate | ~st_q.phase);
	assign fifo_pop.ready = char_evt;
	assign ld       = char_evt & fifo_pop.valid;
	assign ld_word  = fifo_pop.data;

	always_comb begin
		if (dec_mode == RPO_TRI_LOW) begin
			nxt_data   = ld_word[RPO_W_RAW_LSB+2 +: 8];
			nxt_status = {ld_word[RPO_W_COMMA], ld_word[RPO_W_RAW_LSB +: 2]};
		end else begin
			nxt_data   = ld_word[RPO_W_DEC_LSB +: 8];
			nxt_status = ld_word[RPO_W_ST_LSB +: 3];
		end
	end

	// =========================================================
	// apb slave: read data captured in setup, zero-wait access
	logic       apb_setup;
	logic       apb_wr;
	logic       hit_ctrl;
	logic       hit_div;
	logic       hit_stat;
	logic       cfg_wr;
	logic [31:0] rd_mux;

	assign hit_ctrl  = (paddr == RPO_CTRL_OFS);
	assign hit_div   = (paddr == RPO_DIV_OFS);
	assign hit_stat  = (paddr == RPO_STAT_OFS);
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign cfg_wr    = apb_wr & (hit_ctrl | hit_div);
	assign pready    = psel & penable;
	assign pslverr   = psel & penable & ~(hit_ctrl | hit_div | hit_stat);
	assign prdata    = st_q.rdata;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[7:0] = st_q.ctrl;
		end else if (hit_div) begin
			rd_mux[15:0] = st_q.div;
		end else if (hit_stat) begin
			rd_mux[RPO_STAT_LVL_LSB +: 4]  = fifo_level;
			rd_mux[RPO_STAT_FULL_BIT]      = ~fifo_push.ready;
			rd_mux[RPO_STAT_UND_LSB +: 8]  = st_q.underruns;
		end
	end

	// =========================================================
	// next state
	always_comb begin
		st_d = st_q;
		if (apb_setup) begin
			st_d.rdata = rd_mux;
		end
		if (apb_wr && hit_ctrl) begin
			st_d.ctrl = pwdata[7:0];
		end
		if (apb_wr && hit_div) begin
			st_d.div = pwdata[15:0];
		end
		st_d.cnt = tick ? (half_len - 8'h01) : (st_q.cnt - 8'h01);
		if (tick) begin
			st_d.phase   = ~st_q.phase;
			st_d.phase_n = st_q.phase;
		end
		if (ld) begin
			st_d.data   = nxt_data;
			st_d.status = nxt_status;
			st_d.parity = ~^nxt_data;
		end else if (char_evt && st_q.underruns != 8'hff) begin
			// no character ready: outputs hold, the miss is counted
			st_d.underruns = st_q.underruns + 8'h01;
		end
		st_d.gap    = tick ? 8'h00 : ((st_q.gap == 8'hff) ? st_q.gap : st_q.gap + 8'h01);
		st_d.cfg_ok = tick ? ~cfg_wr : (st_q.cfg_ok & ~cfg_wr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q         <= '0;
			st_q.ctrl    <= RPO_CTRL_RST;
			st_q.div     <= RPO_DIV_RST;
			st_q.phase_n <= 1'b1;
			st_q.data    <= RPO_DATA_RST;
			st_q.status  <= RPO_STATUS_RST;
			st_q.parity  <= RPO_PAR_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// =========================================================
	// outputs
	assign rx_data_out             = st_q.data;
	assign rx_status_out           = st_q.status;
	assign rx_odd_parity_out       = st_q.parity;
	assign rx_odd_parity_oe        = (par_ctl != RPO_TRI_LOW);
	assign rx_char_clock_pair_true = st_q.phase;
	assign rx_char_clock_pair_comp = st_q.phase_n;

	// =========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_upd_on_edge;
		($changed(rx_data_out) || $changed(rx_status_out))
			|-> $changed(rx_char_clock_pair_true)
			&& ($past(half_rate) || rx_char_clock_pair_true);
	endproperty
	a_upd_on_edge: assert property (p_upd_on_edge) else $error("output moved off clock edge");

	property p_dec_data;
		(ld && dec_mode != RPO_TRI_LOW) |=> rx_data_out == $past(ld_word[11:4]);
	endproperty
	a_dec_data: assert property (p_dec_data) else $error("decoded byte not presented");

	property p_byp_data;
		(ld && dec_mode == RPO_TRI_LOW) |=> rx_data_out == $past(ld_word[21:14]);
	endproperty
	a_byp_data: assert property (p_byp_data) else $error("raw high bits wrong");

	property p_byp_low;
		(ld && dec_mode == RPO_TRI_LOW) |=> rx_status_out[1:0] == $past(ld_word[13:12]);
	endproperty
	a_byp_low: assert property (p_byp_low) else $error("raw low bits wrong");

	property p_byp_comma;
		(ld && dec_mode == RPO_TRI_LOW) |=> rx_status_out[2] == $past(ld_word[0]);
	endproperty
	a_byp_comma: assert property (p_byp_comma) else $error("comma flag wrong");

	property p_dec_status;
		(ld && dec_mode != RPO_TRI_LOW) |=> rx_status_out == $past(ld_word[3:1]);
	endproperty
	a_dec_status: assert property (p_dec_status) else $error("decoded status wrong");

	property p_par_timed;
		$changed(rx_data_out) |-> $changed(rx_odd_parity_out) == ^($past(rx_data_out) ^ rx_data_out);
	endproperty
	a_par_timed: assert property (p_par_timed) else $error("parity not timed with data");

	property p_par_off;
		(apb_wr && hit_ctrl && pwdata[3:2] == RPO_TRI_LOW) |=> !rx_odd_parity_oe;
	endproperty
	a_par_off: assert property (p_par_off) else $error("parity driver left on");

	property p_clk_pair;
		rx_char_clock_pair_comp != rx_char_clock_pair_true;
	endproperty
	a_clk_pair: assert property (p_clk_pair) else $error("clock pair not complementary");

	property p_rec_rate;
		(tick && st_q.cfg_ok && !use_ref) |-> st_q.gap == half_len - 8'h01;
	endproperty
	a_rec_rate: assert property (p_rec_rate) else $error("recovered clock period wrong");

	property p_full_latch;
		(ld && !half_rate) |=> $rose(rx_char_clock_pair_true);
	endproperty
	a_full_latch: assert property (p_full_latch) else $error("load on wrong edge");

	property p_ref_rate;
		(tick && st_q.cfg_ok && use_ref) |-> st_q.gap == ref_half - 8'h01;
	endproperty
	a_ref_rate: assert property (p_ref_rate) else $error("reference clock period wrong");

	property p_ref_both;
		(tick && use_ref && ref_rate && fifo_pop.valid) |-> ld;
	endproperty
	a_ref_both: assert property (p_ref_both) else $error("half-rate edge skipped");

	property p_par_odd;
		^{rx_data_out, rx_odd_parity_out} == 1'b1;
	endproperty
	a_par_odd: assert property (p_par_odd) else $error("parity not odd");

	c_byp_load: cover property (ld && dec_mode == RPO_TRI_LOW);
	c_ref_half: cover property ((ld && use_ref && ref_rate) ##[1:16] ld);
	c_underrun: cover property (char_evt && !fifo_pop.valid);
	c_fifo_full: cover property (!fifo_push.ready && char_valid);

endmodule

// ### logic/rpo_pkg.sv
// constants shared by the receive parallel output port and its fifo
package rpo_pkg;

	// =========================================================
	// three-level select encoding
	localparam logic [1:0] RPO_TRI_LOW  = 2'h0;
	localparam logic [1:0] RPO_TRI_MID  = 2'h1;
	localparam logic [1:0] RPO_TRI_HIGH = 2'h2;

	// =========================================================
	// apb register map
	localparam int             RPO_ADDR_W    = 12;
	localparam logic [11:0]    RPO_CTRL_OFS  = 12'h000;
	localparam logic [11:0]    RPO_DIV_OFS   = 12'h004;
	localparam logic [11:0]    RPO_STAT_OFS  = 12'h008;

	// ctrl fields
	localparam int RPO_CTRL_DEC_LSB  = 0;
	localparam int RPO_CTRL_PAR_LSB  = 2;
	localparam int RPO_CTRL_SEL_LSB  = 4;
	localparam int RPO_CTRL_RXR_BIT  = 6;
	localparam int RPO_CTRL_REFR_BIT = 7;
	localparam logic [7:0] RPO_CTRL_RST = 8'h12;

	// div fields: recovered char period, reference half period (pclk cycles)
	localparam int RPO_DIV_REC_LSB = 0;
	localparam int RPO_DIV_REF_LSB = 8;
	localparam logic [15:0] RPO_DIV_RST = 16'h050a;

	// stat fields
	localparam int RPO_STAT_LVL_LSB  = 0;
	localparam int RPO_STAT_FULL_BIT = 4;
	localparam int RPO_STAT_UND_LSB  = 8;

	// =========================================================
	// character word carried through the fifo
	localparam int RPO_FIFO_DEPTH  = 8;
	localparam int RPO_CHAR_W      = 22;
	localparam int RPO_W_COMMA     = 0;
	localparam int RPO_W_ST_LSB    = 1;
	localparam int RPO_W_DEC_LSB   = 4;
	localparam int RPO_W_RAW_LSB   = 12;

	// output register reset: all zero data, odd parity bit set
	localparam logic [7:0] RPO_DATA_RST   = 8'h00;
	localparam logic [2:0] RPO_STATUS_RST = 3'h0;
	localparam logic       RPO_PAR_RST    = 1'b1;

endpackage

// ### logic/rpo_stream_if.sv
// valid/ready stream carrier between the port logic and its fifo
`timescale 1ns/1ps
interface rpo_stream_if #(
	parameter int W = 22
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### logic/rpo_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rpo_fifo #(
	parameter int W     = 22,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// streams
	rpo_stream_if.snk             push,
	rpo_stream_if.src             pop,
	// fill level
	output      logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} rpo_fifo_st_t;

	rpo_fifo_st_t st_q;
	rpo_fifo_st_t st_d;
	logic         do_push;
	logic         do_pop;

	assign push.ready = (st_q.cnt != (AW+1)'(DEPTH));
	assign pop.valid  = (st_q.cnt != '0);
	assign pop.data   = st_q.mem[st_q.rp];
	assign level      = st_q.cnt;
	assign do_push    = push.valid & push.ready;
	assign do_pop     = pop.valid & pop.ready;

	always_comb begin
		st_d = st_q;
		if (do_push) begin
			st_d.mem[st_q.wp] = push.data;
			st_d.wp           = st_q.wp + 1'b1;
		end
		if (do_pop) begin
			st_d.rp = st_q.rp + 1'b1;
		end
		if (do_push && !do_pop) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (!do_push && do_pop) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// ### tb/rpo_host_model.sv
// host model that latches characters off the receive parallel port
`timescale 1ns/1ps
module rpo_host_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// port pins
	input  wire logic [7:0]  rx_data_out,
	input  wire logic [2:0]  rx_status_out,
	input  wire logic        rx_char_clock_pair_true,
	// host configuration
	input  wire logic        half_rate,
	// results
	output      logic [10:0] last_q,
	output      int          latch_cnt,
	output      int          timing_err
);
	logic        true_q;
	logic [10:0] prev_q;
	logic [10:0] hist[$];

	// ==========
	// latch
	// sampled one pclk late so the host never races the launching edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			true_q <= 1'b0;
			prev_q <= '0;
			last_q <= '0;
			latch_cnt <= 0;
			timing_err <= 0;
		end else begin
			true_q <= rx_char_clock_pair_true;
			prev_q <= {rx_status_out, rx_data_out};
			if ({rx_status_out, rx_data_out} != prev_q && rx_char_clock_pair_true == true_q) begin
				timing_err <= timing_err + 1;
			end
			if (rx_char_clock_pair_true != true_q && (half_rate || rx_char_clock_pair_true)) begin
				latch_cnt <= latch_cnt + 1;
				last_q <= {rx_status_out, rx_data_out};
				if (hist.size() == 0 || hist[$] != {rx_status_out, rx_data_out}) begin
					hist.push_back({rx_status_out, rx_data_out});
				end
			end
		end
	end
endmodule

// ### tb/receive_parallel_output_port_bench.sv
// self-checking bench for the receive parallel output port
`timescale 1ns/1ps
module receive_parallel_output_port_bench import rpo_pkg::*; ;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        char_valid;
	logic        char_ready;
	logic [9:0]  char_raw;
	logic [7:0]  char_dec_data;
	logic [2:0]  char_dec_status;
	logic        char_comma;
	logic [7:0]  rx_data_out;
	logic [2:0]  rx_status_out;
	logic        rx_odd_parity_out;
	logic        rx_odd_parity_oe;
	logic        clk_t;
	logic        clk_c;
	logic        half_rate;
	logic [10:0] host_last;
	int          host_cnt;
	int          host_err;
	int          miscompares;
	int          tests_run;

	rpo_rx_out_port u_rpo_rx_out_port (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .char_valid(char_valid),
		.char_ready(char_ready), .char_raw(char_raw), .char_dec_data(char_dec_data),
		.char_dec_status(char_dec_status), .char_comma(char_comma),
		.rx_data_out(rx_data_out), .rx_status_out(rx_status_out),
		.rx_odd_parity_out(rx_odd_parity_out), .rx_odd_parity_oe(rx_odd_parity_oe),
		.rx_char_clock_pair_true(clk_t), .rx_char_clock_pair_comp(clk_c)
	);

	rpo_host_model u_rpo_host_model (
		.pclk(pclk), .presetn(presetn), .rx_data_out(rx_data_out),
		.rx_status_out(rx_status_out), .rx_char_clock_pair_true(clk_t),
		.half_rate(half_rate), .last_q(host_last), .latch_cnt(host_cnt),
		.timing_err(host_err)
	);

	// ==========
	// helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rdv, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic        e;
		apb(1'b1, a, wd, d, e);
		// the write lands at the access edge; let it settle before anyone looks
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		chk("reg", ex, d);
	endtask

	task automatic push(input logic [9:0] r, input logic [7:0] dd, input logic [2:0] ds,
		input logic cm);
		@(posedge pclk);
		char_valid <= 1'b1;
		char_raw <= r;
		char_dec_data <= dd;
		char_dec_status <= ds;
		char_comma <= cm;
		do @(posedge pclk); while (char_ready !== 1'b1);
		char_valid <= 1'b0;
	endtask

	task automatic wait_latch(input int n);
		int c;
		c = host_cnt;
		while (host_cnt < c + n) @(posedge pclk);
	endtask

	task automatic tog(output int n);
		logic t;
		t = clk_t;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (clk_t === t);
		chk("comp", 32'h1, 32'(clk_t ^ clk_c));
	endtask

	// settles on the new setting, then times one half period
	task automatic measure(input logic [31:0] ctl, input logic hr, input int ex);
		int n;
		half_rate <= hr;
		wr(RPO_CTRL_OFS, ctl);
		repeat (4) tog(n);
		chk("half period", 32'(ex), 32'(n));
	endtask

	// ==========
	// scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic        e;
		chk("data", 0, 32'(rx_data_out));
		chk("status", 0, 32'(rx_status_out));
		chk("parity", 1, 32'(rx_odd_parity_out));
		chk("parity oe", 0, 32'(rx_odd_parity_oe));
		rd(RPO_CTRL_OFS, 32'h12);
		rd(RPO_DIV_OFS, 32'h050a);
		apb(1'b0, 12'h00c, 32'h0, d, e);
		chk("unmapped err", 1, 32'(e));
		chk("unmapped data", 0, d);
	endtask

	task automatic t_dec();
		logic [7:0] v[2] = '{8'ha5, 8'h07};
		wr(RPO_CTRL_OFS, 32'h16);
		chk("parity oe", 1, 32'(rx_odd_parity_oe));
		for (int i = 0; i < 2; i++) begin
			push(10'h3ff, v[i], 3'(i + 4), 1'b1);
			wait_latch(2);
			chk("decoded", {21'h0, 3'(i + 4), v[i]}, 32'(host_last));
			chk("parity", 32'(~^v[i]), 32'(rx_odd_parity_out));
		end
	endtask

	task automatic t_byp();
		logic [9:0] r[2] = '{10'h2d6, 10'h13d};
		wr(RPO_CTRL_OFS, 32'h14);
		for (int i = 0; i < 2; i++) begin
			push(r[i], 8'hee, 3'h7, 1'(i == 0));
			wait_latch(2);
			chk("raw", {21'h0, 1'(i == 0), r[i][1:0], r[i][9:2]}, 32'(host_last));
		end
		wr(RPO_CTRL_OFS, 32'h10);
		chk("parity oe", 0, 32'(rx_odd_parity_oe));
	endtask

	task automatic t_rates();
		wr(RPO_DIV_OFS, 32'h0308);
		measure(32'h12, 1'b0, 4);
		measure(32'h52, 1'b1, 8);
		measure(32'h42, 1'b0, 3);
		measure(32'h82, 1'b1, 3);
		// half-rate reference clocking loads on both clock edges
		push(10'h0, 8'h3c, 3'h2, 1'b0);
		push(10'h0, 8'hc3, 3'h5, 1'b0);
		wait_latch(3);
		chk("half rate", 32'h5c3, 32'(host_last));
		chk("half rate prev", 32'h23c, 32'(u_rpo_host_model.hist[$-1]));
	endtask

	task automatic t_fill();
		logic [31:0] d;
		logic        e;
		int          n;
		int          b;
		wr(RPO_DIV_OFS, 32'h05ff);
		measure(32'h12, 1'b0, 127);
		// start right after a rising true edge so no pop lands inside the fill
		do tog(n); while (clk_t !== 1'b1);
		for (int i = 0; i < 8; i++) push(10'h0, 8'(8'h10 + i), 3'(i), 1'b0);
		@(posedge pclk);
		chk("char ready", 0, 32'(char_ready));
		apb(1'b0, RPO_STAT_OFS, 32'h0, d, e);
		chk("stat", 32'h18, {27'h0, d[4:0]});
		wait_latch(9);
		b = u_rpo_host_model.hist.size() - 8;
		for (int i = 0; i < 8; i++) begin
			chk("order", {21'h0, 3'(i), 8'(8'h10 + i)}, 32'(u_rpo_host_model.hist[b + i]));
		end
	endtask

	task automatic end_sim();
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========
	// clock, reset, sequence
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		end_sim();
	end

	initial begin
		{presetn, psel, penable, pwrite, char_valid, char_comma, half_rate} = '0;
		paddr = '0;
		pwdata = '0;
		char_raw = '0;
		char_dec_data = '0;
		char_dec_status = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_dec();
		t_byp();
		t_rates();
		t_fill();
		chk("timing", 0, 32'(host_err));
		end_sim();
	end
endmodule
